// ===== gsf_pkg.sv
// Package for the gas sensor status frame encoder.
// Assumes a single 10 MHz core clock; all timing counts derive from it.
package gsf_pkg;

  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned FIRST_FRAME_MS   = 700;
  localparam int unsigned FRAME_PERIOD_MS  = 100;
  localparam int unsigned FIRST_FRAME_CYC  = FIRST_FRAME_MS * (CLK_HZ / 1000);
  localparam int unsigned FRAME_PERIOD_CYC = FRAME_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned US_CYC           = CLK_HZ / 1_000_000;

  // Pulse-width output timing in microseconds
  localparam int unsigned PWM_PERIOD_US = 255;
  localparam logic [7:0]  PWM_ERR_US    = 8'h0a;

  // Concentration code scale
  localparam logic [7:0]  CODE_ZERO     = 8'h14;
  localparam logic [7:0]  CODE_FULL     = 8'hf0;
  localparam int unsigned PPM_PER_STEP  = 200;

  localparam logic [15:0] CRC_POLY      = 16'h1021;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [7:0]  COUNTER_START = 8'h01;
  localparam logic [10:0] ID_BASE       = 11'h640;

  // Status encodings
  localparam logic [1:0] ST_OK        = 2'h0;
  localparam logic [1:0] ST_MINOR     = 2'h1;
  localparam logic [1:0] ST_REPLACE   = 2'h2;
  localparam logic [1:0] ST_FATAL     = 2'h3;

  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic [7:0] b6;
    logic [7:0] b7;
  } gsf_frame_t;

  typedef struct packed {
    logic [15:0] ppm;
    logic [9:0]  raw_transducer_reading;
    logic [1:0]  status;
    logic [4:0]  release_num;
  } gsf_meas_t;

endpackage

// ===== gsf_encoder.sv
// Gas sensor status frame encoder: builds the periodic eight-byte
// status_report_frame and an alternative pulse-width bus output.
// Assumes an external CAN controller that takes o_frame on o_frame_valid.
`timescale 1ns/10ps
module gsf_encoder #(
  parameter int unsigned FIRST_CYC  = gsf_pkg::FIRST_FRAME_CYC,
  parameter int unsigned PERIOD_CYC = gsf_pkg::FRAME_PERIOD_CYC
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_sys_rst,
  input  wire gsf_pkg::gsf_meas_t i_meas,
  input  wire logic               i_pwm_mode,
  input  wire logic               i_supply_feed_zero,
  input  wire logic               i_supply_feed_one,
  input  wire logic               i_supply_feed_two,
  output gsf_pkg::gsf_frame_t     o_frame,
  output logic [10:0]             o_bus_id,
  output logic                    o_frame_valid,
  output logic                    o_bus_h,
  output logic                    o_bus_l,
  output logic                    o_bus_oe
);
  import gsf_pkg::*;

  // Concentration code with round-to-nearest and clamp to full scale
  function automatic logic [7:0] conc_code(input logic [15:0] ppm);
    logic [16:0] q;
    q = 17'((17'(ppm) + 17'(PPM_PER_STEP / 2)) / 17'(PPM_PER_STEP));
    if (q > 17'(CODE_FULL - CODE_ZERO)) begin
      q = 17'(CODE_FULL - CODE_ZERO);
    end
    conc_code = 8'(q) + CODE_ZERO;
  endfunction

  // One byte of CCITT CRC, MSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    crc_byte = r;
  endfunction

  // Feed straps pass three flops; a change counts when stages 2 and 3 agree
  logic [2:0] feed_s1;
  logic [2:0] feed_s2;
  logic [2:0] feed_s3;
  logic [2:0] sensor_num;
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      feed_s1 <= 3'h0;
      feed_s2 <= 3'h0;
      feed_s3 <= 3'h0;
    end else begin
      feed_s1 <= {i_supply_feed_two, i_supply_feed_one, i_supply_feed_zero};
      feed_s2 <= feed_s1;
      feed_s3 <= feed_s2;
    end
  end

  // Sensor number follows the stable strap
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sensor_num <= 3'h0;
    end else if (feed_s2 == feed_s3) begin
      sensor_num <= feed_s3;
    end
  end

  // Frame scheduler: 700 ms first, then every 100 ms
  logic [31:0] frame_cnt;
  logic        first_done;
  logic [7:0]  msg_cnt;
  wire         frame_tick = (frame_cnt == 32'd0);
  wire  [31:0] reload     = 32'(PERIOD_CYC - 1);
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      frame_cnt  <= 32'(FIRST_CYC - 1);
      first_done <= 1'b0;
    end else if (frame_tick) begin
      frame_cnt  <= reload;
      first_done <= 1'b1;
    end else begin
      frame_cnt  <= frame_cnt - 32'd1;
    end
  end

  // Counter starts at 1 and steps after each frame, wrapping naturally
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      msg_cnt <= COUNTER_START;
    end else if (frame_tick && !i_pwm_mode) begin
      msg_cnt <= msg_cnt + 8'h01;
    end
  end

  // Payload assembly
  wire [7:0] code     = conc_code(i_meas.ppm);
  wire [9:0] pv_base  = {i_meas.status, code};
  wire [9:0] pv_sum   = pv_base + {8'h00, msg_cnt[1:0]};
  wire [9:0] check_word = (~pv_sum) + 10'h001;
  wire [7:0] check_word_low_byte = check_word[7:0];
  wire [1:0] check_word_top_bits = check_word[9:8];
  wire [7:0] byte0 = code;
  wire [7:0] byte2 = i_meas.raw_transducer_reading[9:2];
  wire [7:0] byte4 = {i_meas.raw_transducer_reading[1:0], 1'b0,
                      sensor_num, check_word_top_bits};
  wire [7:0] byte6 = {i_meas.release_num, i_meas.status, 1'b0};
  // byte6 above carries release and status fields
  wire [15:0] crc = crc_byte(crc_byte(crc_byte(crc_byte(crc_byte(
                    crc_byte(CRC_INIT, byte0), check_word_low_byte),
                    byte2), byte4), msg_cnt), byte6);
  // Sensor 1 owns the base identifier; an unstrapped part falls back to it
  wire [2:0]  id_step = (sensor_num == 3'h0) ? 3'h0 : sensor_num - 3'h1;
  wire [10:0] bus_id  = ID_BASE + {5'h00, id_step, 3'h0};

  // Frame output latched at the scheduled tick
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_frame       <= '0;
      o_bus_id      <= ID_BASE;
      o_frame_valid <= 1'b0;
    end else begin
      o_frame_valid <= frame_tick && !i_pwm_mode;
      if (frame_tick) begin
        o_frame  <= {byte0, check_word_low_byte, byte2, crc[15:8],
                     byte4, msg_cnt, byte6, crc[7:0]};
        o_bus_id <= bus_id;
      end
    end
  end

  // Pulse-width variant: microsecond ticks then a 255 us period
  logic [7:0] us_div;
  logic [7:0] us_pos;
  logic [7:0] width;
  wire        us_tick = (us_div == 8'(US_CYC - 1));
  wire        err     = (i_meas.status == ST_FATAL);
  // Width sampled at each period start so a pulse is never cut short
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      us_div <= 8'h00;
      us_pos <= 8'h00;
      width  <= CODE_ZERO;
    end else begin
      us_div <= us_tick ? 8'h00 : us_div + 8'h01;
      if (us_tick) begin
        if (us_pos == 8'(PWM_PERIOD_US - 1)) begin
          us_pos <= 8'h00;
          width  <= err ? PWM_ERR_US : code;
        end else begin
          us_pos <= us_pos + 8'h01;
        end
      end
    end
  end

  // Recessive: both lines undriven; dominant: pulled apart
  wire dominant = i_pwm_mode && first_done && (us_pos >= width);
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_bus_h  <= 1'b0;
      o_bus_l  <= 1'b0;
      o_bus_oe <= 1'b0;
    end else begin
      o_bus_h  <= dominant;
      o_bus_l  <= 1'b0;
      o_bus_oe <= dominant;
    end
  end

endmodule

// ===== gsf_encoder_properties.sv
// Port checker for the status frame encoder, bound into each instance.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/10ps
module gsf_props #(
  parameter int unsigned FIRST_CYC  = 50,
  parameter int unsigned PERIOD_CYC = 20
) (
  input wire logic                i_core_clk,
  input wire logic                i_sys_rst,
  input wire gsf_pkg::gsf_meas_t  i_meas,
  input wire logic                i_pwm_mode,
  input wire gsf_pkg::gsf_frame_t o_frame,
  input wire logic [10:0]         o_bus_id,
  input wire logic                o_frame_valid,
  input wire logic                o_bus_h,
  input wire logic                o_bus_l,
  input wire logic                o_bus_oe
);
  import gsf_pkg::*;
  localparam int FA = FIRST_CYC - 2;
  localparam int FB = FIRST_CYC;
  localparam int PD = PERIOD_CYC;
  logic [9:0] exp_chk;
  // Check word rebuilt from the code, status and count it guards
  assign exp_chk = 10'h0 - ({o_frame.b6[2:1], o_frame.b0} + o_frame.b5[1:0]);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  valid_single_a: assert property (o_frame_valid |=> !o_frame_valid)
    else $error("valid too long");
  frame_period_a: assert property (o_frame_valid |-> ##PD (o_frame_valid
    && o_frame.b5 == $past(o_frame.b5, PD) + 8'h01)) else $error("bad count");
  first_frame_a: assert property ($fell(i_sys_rst) && !i_pwm_mode
    |-> ##[FA:FB] (o_frame_valid && o_frame.b5 == 8'h01)) else $error("late");
  check_word_a: assert property (o_frame_valid
    |-> {o_frame.b4[1:0], o_frame.b1} == exp_chk) else $error("bad check");
  bus_id_a: assert property (o_frame_valid && o_frame.b4[4:2] != 3'h0
    |-> o_bus_id == ID_BASE + {o_frame.b4[4:2] - 3'h1, 3'h0})
    else $error("bad id");
  status_field_a: assert property (o_frame_valid |-> o_frame.b6 ==
    {$past(i_meas.release_num), $past(i_meas.status), 1'b0})
    else $error("bad status");
  bus_pins_a: assert property (!o_bus_l && o_bus_h == o_bus_oe)
    else $error("bad pins");
  pwm_quiet_a: assert property (i_pwm_mode |-> !o_frame_valid)
    else $error("frame in pwm");
  cover property (o_frame_valid && o_frame.b5 == 8'h00);
  cover property ($fell(o_bus_oe));
  cover property (o_frame_valid && o_frame.b6[2:1] == ST_FATAL);
endmodule
bind gsf_encoder gsf_props #(.FIRST_CYC(FIRST_CYC), .PERIOD_CYC(PERIOD_CYC))
  u_props (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_meas(i_meas),
  .i_pwm_mode(i_pwm_mode), .o_frame(o_frame), .o_bus_id(o_bus_id),
  .o_frame_valid(o_frame_valid), .o_bus_h(o_bus_h), .o_bus_l(o_bus_l),
  .o_bus_oe(o_bus_oe));

// ===== gsf_vcu_model.sv
// Control unit model: counts frames and times the pulse-width output.
// Assumes frames come on the one-cycle valid strobe.
`timescale 1ns/10ps
module gsf_vcu_model (
  input  wire logic i_core_clk,
  input  wire logic i_frame_valid,
  input  wire logic i_bus_oe,
  output int        o_count = 0,
  output int        o_rec_w = 0,
  output int        o_per   = 0
);
  int   rc   = 0;
  logic oe_q = 1'b0;
  int   pc   = 0;
  // Low oe is recessive; runs are timed between edges, so pin lag cancels
  always @(posedge i_core_clk) begin
    oe_q <= i_bus_oe;
    rc   <= i_bus_oe ? 0 : rc + 1;
    pc   <= (oe_q && !i_bus_oe) ? 1 : pc + 1;
    if (i_frame_valid) o_count <= o_count + 1;
    if (i_bus_oe && !oe_q) o_rec_w <= rc;
    if (oe_q && !i_bus_oe) o_per <= pc;
  end
endmodule

// ===== tb_gas_sensor_status_frame_encoder.sv
// Bench: frame fields, counter wrap, then the pulse-width output.
// Assumes the checker binds itself to the design.
`timescale 1ns/10ps
module tb_gas_sensor_status_frame_encoder;
  import gsf_pkg::*;
  localparam logic [15:0] PPM_TAB [6] = '{16'h0000, 16'h0064, 16'h012b,
                                          16'habe0, 16'hc350, 16'h03e8};
  logic       clk  = 1'b0;
  logic       rst  = 1'b1;
  logic       pwm  = 1'b0;
  logic [2:0] feed = 3'h5;
  logic [7:0] cnt  = 8'h01;
  gsf_meas_t  meas = '0;
  gsf_frame_t frame;
  logic [10:0] bus_id;
  logic        valid;
  logic        bus_oe;
  int          n_seen, rec_w, per, n, k;
  int          err_total = 0, n_compared = 0, cyc = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  // Ceiling well above the 16000 or so cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      stop_test();
    end
  end
  gsf_encoder #(.FIRST_CYC(50), .PERIOD_CYC(20)) dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_meas(meas), .i_pwm_mode(pwm),
    .i_supply_feed_zero(feed[0]), .i_supply_feed_one(feed[1]),
    .i_supply_feed_two(feed[2]), .o_frame(frame), .o_bus_id(bus_id),
    .o_frame_valid(valid), .o_bus_h(), .o_bus_l(), .o_bus_oe(bus_oe));
  gsf_vcu_model u_vcu (.i_core_clk(clk), .i_frame_valid(valid),
    .i_bus_oe(bus_oe), .o_count(n_seen), .o_rec_w(rec_w), .o_per(per));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Reference frame; CRC runs MSB first and skips its own two bytes
  function automatic gsf_frame_t exp_fr(gsf_meas_t m, logic [7:0] c,
                                        logic [2:0] s);
    logic [7:0]  cd;
    logic [9:0]  ck;
    logic [15:0] r;
    logic [47:0] d;
    gsf_frame_t  f;
    cd = (m.ppm > 16'hab7b) ? CODE_FULL
       : 8'((m.ppm + 32'h64) / 32'hc8) + CODE_ZERO;
    ck = 10'h0 - ({m.status, cd} + c[1:0]);
    f = {cd, ck[7:0], m.raw_transducer_reading[9:2], 8'h00,
         m.raw_transducer_reading[1:0], 1'b0, s, ck[9:8], c,
         m.release_num, m.status, 1'b0, 8'h00};
    d = {f.b0, f.b1, f.b2, f.b4, f.b5, f.b6};
    r = CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    end
    f.b3 = r[15:8];
    f.b7 = r[7:0];
    return f;
  endfunction
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    // 260 frames walk codes and statuses and carry the counter past 255
    for (int i = 0; i < 260; i++) begin
      n = n_seen;
      for (k = 0; k < 80 && n_seen == n; k++) @(negedge clk);
      chk(frame, exp_fr(meas, cnt, feed));
      chk(bus_id, ID_BASE + {feed - 3'h1, 3'h0});
      cnt++;
      if (i == 100) feed = 3'h7;
      meas = '{PPM_TAB[i % 6], 10'(i * 37), 2'(i), 5'(i)};
    end
    @(negedge clk);
    rst  = 1'b1;
    pwm  = 1'b1;
    meas = '{16'h00c8, 10'h000, ST_OK, 5'h00};
    n    = n_seen;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (5200) @(negedge clk);
    chk(rec_w, 64'h00d2);
    chk(per, 64'h09f6);
    meas.status = ST_FATAL;
    repeat (5200) @(negedge clk);
    chk(rec_w, 64'h0064);
    chk(n_seen, n);
    stop_test();
  end
endmodule
